/* File: core/lss_defines.vh */
// Constants for the line sense status block: register indices, field positions,
// reset values and timing counts. Definitions only; included by every design file.
//
// Summary of operation
// - Sense field bits 7:3 shows voltage, current or monitor value per mode settings.
// - On-hook sense code is line voltage (monitor code when monitor enabled), 2.75 V steps, 00000 none, 11111 maximum.
// - Off-hook sense code is loop current (line voltage when mode bit set), 3 mA steps, 1 minimum, 30 maximum normal.
// - Off-hook current above overload limit saturates the sense code at 11111 when the mode bit is clear.
// - Overload limit is 140 mA, except 54 mA in European harmonised mode.
// - Bit 2 mirrors receive overload, reads one while excessive, clears by itself.
// - Bit 2 masked only by the off-hook settling counter; billing enable ignored.
// - Off-hook, supply collapse sets the dropout flag to one.
// - Dropout flag clears sixteen sample frames after the supply returns.
// - Dropout flag held at zero while on-hook.
// - Bit 0 reads one while overload protection circuit is active and protection is enabled by control bit 5.
`ifndef LSS_DEFINES_VH
`define LSS_DEFINES_VH

// Register indices; byte address is four times the index
`define LSS_IDX_SENSE_STATUS 8'h13
`define LSS_IDX_CONTROL      8'h20
`define LSS_IDX_IRQ_STATUS   8'h21
`define LSS_IDX_IRQ_MASK     8'h22

// Sense status fields
`define LSS_SENSE_CODE_MSB   7
`define LSS_SENSE_CODE_LSB   3
`define LSS_RX_OVERLOAD_BIT  2
`define LSS_DROPOUT_BIT      1
`define LSS_PROTECT_BIT      0
`define LSS_SENSE_RESET      8'h00

// Control fields
`define LSS_CTL_HOOK_BIT     0
`define LSS_CTL_MONITOR_BIT  1
`define LSS_CTL_MODE_BIT     2
`define LSS_CTL_EURO_BIT     3
`define LSS_CTL_BILL_BIT     4
`define LSS_CTL_PROT_EN_BIT  5
`define LSS_CTL_WIDTH        6
`define LSS_CTL_RESET        6'h00

// Interrupt fields (status and mask share the layout)
`define LSS_IRQ_RX_EXCESS_BIT  0
`define LSS_IRQ_DROPOUT_BIT    1
`define LSS_IRQ_PROTECT_BIT    2
`define LSS_IRQ_CUR_LIMIT_BIT  3
`define LSS_IRQ_WIDTH          4
`define LSS_IRQ_RESET          4'h0

// Sense codes
`define LSS_CODE_ZERO        5'h00
`define LSS_CODE_MAX_NORMAL  5'h1E
`define LSS_CODE_SATURATED   5'h1F

// Timing counts in sample frames
`define LSS_DROPOUT_FRAMES   16
`define LSS_SETTLE_FRAMES    8

`endif

/* File: core/lss_sense_code.v */
// Sense code selector: picks voltage, current or monitor code and saturates on
// overload. Expects quantizer codes and comparator levels synchronous to mclk_in.
`timescale 1ns/1ns
`include "lss_defines.vh"
module lss_sense_code (
  input  wire       mclk_in,          // System clock
  input  wire       reset_in,         // Synchronous reset, active high
  input  wire       off_hook_in,      // Hook state, 1 = off-hook
  input  wire       monitor_en_in,    // On-hook monitor enable
  input  wire       mode_in,          // Off-hook shows line voltage when set
  input  wire       euro_in,          // European harmonised mode
  input  wire [4:0] volt_code_in,     // Line voltage code, 2.75 V per step
  input  wire [4:0] monitor_code_in,  // On-hook monitor code
  input  wire [4:0] current_code_in,  // Loop current code, 3 mA per step
  input  wire       over_high_in,     // Current above 140 mA
  input  wire       over_low_in,      // Current above 54 mA
  output reg  [4:0] code_out,         // Selected sense code
  output reg        cur_limit_out     // Current overload level
);

  reg  [4:0] nxt_code;
  reg        nxt_limit;

  // *********************************************************
  // Code selection
  // *********************************************************
  // Off-hook current below the floor reports zero as quantized by the front end
  always @* begin
    nxt_limit = 1'b0;
    nxt_code  = `LSS_CODE_ZERO;
    if (!off_hook_in) begin
      if (monitor_en_in) begin
        nxt_code = monitor_code_in;
      end else begin
        nxt_code = volt_code_in;
      end
    end else if (mode_in) begin
      nxt_code = volt_code_in;
    end else begin
      nxt_limit = euro_in ? over_low_in : over_high_in;
      if (nxt_limit) begin
        nxt_code = `LSS_CODE_SATURATED;
      end else if (current_code_in > `LSS_CODE_MAX_NORMAL) begin
        nxt_code = `LSS_CODE_MAX_NORMAL;
      end else begin
        nxt_code = current_code_in;
      end
    end
  end

  // Registered so the status bits change once per clock
  always @(posedge mclk_in) begin
    if (reset_in) begin
      code_out      <= `LSS_CODE_ZERO;
      cur_limit_out <= 1'b0;
    end else begin
      code_out      <= nxt_code;
      cur_limit_out <= nxt_limit;
    end
  end

endmodule // lss_sense_code

/* File: core/lss_dropout.v */
// Supply dropout detector: sets on collapse while off-hook, releases after a
// number of sample frames of good supply. Frame strobe is one mclk_in cycle wide.
`timescale 1ns/1ns
`include "lss_defines.vh"
module lss_dropout #(
  parameter FRAMES = `LSS_DROPOUT_FRAMES   // Frames of good supply before release
) (
  input  wire mclk_in,       // System clock
  input  wire reset_in,      // Synchronous reset, active high
  input  wire off_hook_in,   // Hook state, 1 = off-hook
  input  wire supply_ok_in,  // Line-derived supply good
  input  wire frame_tick_in, // One pulse per sample frame
  output reg  dropout_out    // Dropout flag
);

  reg [4:0] count_ff;

  // *********************************************************
  // Dropout flag and release counter
  // *********************************************************
  // Counter restarts on every collapse so a bouncing supply keeps the flag up
  always @(posedge mclk_in) begin
    if (reset_in) begin
      dropout_out <= 1'b0;
      count_ff    <= 5'h00;
    end else if (!off_hook_in) begin
      dropout_out <= 1'b0;
      count_ff    <= 5'h00;
    end else if (!supply_ok_in) begin
      dropout_out <= 1'b1;
      count_ff    <= 5'h00;
    end else if (dropout_out && frame_tick_in) begin
      if (count_ff == FRAMES[4:0] - 5'h01) begin
        dropout_out <= 1'b0;
        count_ff    <= 5'h00;
      end else begin
        count_ff <= count_ff + 5'h01;
      end
    end
  end

endmodule // lss_dropout

/* File: core/lss_top.v */
// Line sense status block: read-only sense status register with control,
// interrupt status and mask registers behind an AHB-Lite slave.
// Assumes all analog-derived inputs are synchronous to mclk_in and that a
// single AHB-Lite master drives whole-word single transfers.
`timescale 1ns/1ns
`include "lss_defines.vh"
module lss_top #(
  parameter SETTLE_FRAMES  = `LSS_SETTLE_FRAMES,  // Frames of rx overload masking after off-hook
  parameter DROPOUT_FRAMES = `LSS_DROPOUT_FRAMES  // Frames of good supply before dropout release
) (
  input  wire        mclk_in,            // System clock, 10 MHz
  input  wire        reset_in,           // Synchronous reset, active high
  // AHB-Lite slave
  input  wire        hsel_in,            // Slave select
  input  wire [31:0] haddr_in,           // Byte address
  input  wire [1:0]  htrans_in,          // Transfer type
  input  wire        hwrite_in,          // Write when high
  input  wire [2:0]  hsize_in,           // Transfer size
  input  wire [31:0] hwdata_in,          // Write data
  input  wire        hready_in,          // Bus ready
  output reg  [31:0] hrdata_out,         // Read data
  output reg         hreadyout_out,      // Slave ready
  output reg         hresp_out,          // Response, always OKAY
  output reg         irq_out,            // Interrupt, level high
  // Line-side sensing
  input  wire [4:0]  volt_code_in,       // Line voltage quantizer
  input  wire [4:0]  monitor_code_in,    // On-hook monitor quantizer
  input  wire [4:0]  current_code_in,    // Loop current quantizer
  input  wire        over_high_in,       // Current above high limit
  input  wire        over_low_in,        // Current above low limit
  input  wire        rx_excess_in,       // Receive level excessive
  input  wire        supply_ok_in,       // Line-derived supply good
  input  wire        protect_circuit_in, // Protection circuit clamping
  input  wire        frame_tick_in,      // One pulse per sample frame
  output reg         off_hook_out,       // Hook control to line side
  output reg         rx_overload_latched_flag_out // Latched receive overload
);

  // *********************************************************
  // Declarations
  // *********************************************************
  reg  [`LSS_CTL_WIDTH-1:0] ctl_ff;
  reg  [`LSS_IRQ_WIDTH-1:0] irq_status_ff;
  reg  [`LSS_IRQ_WIDTH-1:0] irq_mask_ff;
  reg  [`LSS_IRQ_WIDTH-1:0] event_prev_ff;
  reg                       wr_pend_ff;
  reg  [7:0]                wr_idx_ff;
  reg  [4:0]                settle_cnt_ff;
  reg                       settle_active_ff;
  reg                       hook_prev_ff;
  reg                       rx_overload_live_flag_ff;
  reg                       overload_protect_active_flag_ff;
  reg                       rx_overload_latched_flag_ff;

  wire [4:0]                line_sense_code;
  wire                      cur_limit;
  wire                      supply_dropout_flag;
  wire [7:0]                line_sense_status;
  wire [`LSS_IRQ_WIDTH-1:0] event_level;
  wire [`LSS_IRQ_WIDTH-1:0] event_rise;
  wire                      addr_phase;
  wire [7:0]                acc_idx;
  wire                      word_ok;

  reg  [`LSS_CTL_WIDTH-1:0] nxt_ctl;
  reg  [`LSS_IRQ_WIDTH-1:0] nxt_irq_status;
  reg  [`LSS_IRQ_WIDTH-1:0] nxt_irq_mask;
  reg  [31:0]               nxt_hrdata;

  wire hook_state_select           = ctl_ff[`LSS_CTL_HOOK_BIT];
  wire on_hook_monitor_enable      = ctl_ff[`LSS_CTL_MONITOR_BIT];
  wire sense_mode                  = ctl_ff[`LSS_CTL_MODE_BIT];
  wire european_harmonised_mode    = ctl_ff[`LSS_CTL_EURO_BIT];
  wire overload_protect_enable     = ctl_ff[`LSS_CTL_PROT_EN_BIT];

  // *********************************************************
  // Sensing sub-blocks
  // *********************************************************
  lss_sense_code u_sense (
    .mclk_in         (mclk_in),
    .reset_in        (reset_in),
    .off_hook_in     (hook_state_select),
    .monitor_en_in   (on_hook_monitor_enable),
    .mode_in         (sense_mode),
    .euro_in         (european_harmonised_mode),
    .volt_code_in    (volt_code_in),
    .monitor_code_in (monitor_code_in),
    .current_code_in (current_code_in),
    .over_high_in    (over_high_in),
    .over_low_in     (over_low_in),
    .code_out        (line_sense_code),
    .cur_limit_out   (cur_limit)
  );

  lss_dropout #(
    .FRAMES (DROPOUT_FRAMES)
  ) u_dropout (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .off_hook_in   (hook_state_select),
    .supply_ok_in  (supply_ok_in),
    .frame_tick_in (frame_tick_in),
    .dropout_out   (supply_dropout_flag)
  );

  // *********************************************************
  // Off-hook settling counter
  // *********************************************************
  // Starts on every on-to-off-hook transition and runs a number of frames;
  // going back on-hook stops it so a stale count never masks a later call
  always @(posedge mclk_in) begin
    if (reset_in) begin
      hook_prev_ff     <= 1'b0;
      settle_cnt_ff    <= 5'h00;
      settle_active_ff <= 1'b0;
    end else begin
      hook_prev_ff <= hook_state_select;
      if (!hook_state_select) begin
        settle_cnt_ff    <= 5'h00;
        settle_active_ff <= 1'b0;
      end else if (!hook_prev_ff) begin
        settle_cnt_ff    <= 5'h00;
        settle_active_ff <= 1'b1;
      end else if (settle_active_ff && frame_tick_in) begin
        if (settle_cnt_ff == SETTLE_FRAMES[4:0] - 5'h01) begin
          settle_active_ff <= 1'b0;
        end else begin
          settle_cnt_ff <= settle_cnt_ff + 5'h01;
        end
      end
    end
  end

  // *********************************************************
  // Receive overload and protection flags
  // *********************************************************
  // Live flag follows the input so it drops by itself; only the settling
  // counter masks it, the billing tone enable is deliberately not consulted
  always @(posedge mclk_in) begin
    if (reset_in) begin
      rx_overload_live_flag_ff        <= 1'b0;
      rx_overload_latched_flag_ff     <= 1'b0;
      overload_protect_active_flag_ff <= 1'b0;
    end else begin
      rx_overload_live_flag_ff <= rx_excess_in & ~settle_active_ff;
      // Latched copy holds until the overload interrupt bit is cleared
      if (rx_excess_in && !settle_active_ff) begin
        rx_overload_latched_flag_ff <= 1'b1;
      end else if (!irq_status_ff[`LSS_IRQ_RX_EXCESS_BIT]) begin
        rx_overload_latched_flag_ff <= 1'b0;
      end
      // Protection only clamps when software has enabled it
      overload_protect_active_flag_ff <= protect_circuit_in & overload_protect_enable;
    end
  end

  // Assemble the read-only status byte
  assign line_sense_status = {line_sense_code,
                              rx_overload_live_flag_ff,
                              supply_dropout_flag,
                              overload_protect_active_flag_ff};

  // *********************************************************
  // Interrupt events
  // *********************************************************
  assign event_level = {cur_limit,
                        overload_protect_active_flag_ff,
                        supply_dropout_flag,
                        rx_overload_live_flag_ff};

  // Rising edges only, so a standing condition does not refire after a clear
  assign event_rise = event_level & ~event_prev_ff;

  always @(posedge mclk_in) begin
    if (reset_in) begin
      event_prev_ff <= `LSS_IRQ_RESET;
    end else begin
      event_prev_ff <= event_level;
    end
  end

  // *********************************************************
  // AHB-Lite address phase
  // *********************************************************
  assign addr_phase = hsel_in & htrans_in[1] & hready_in;
  assign acc_idx    = haddr_in[9:2];
  // Only aligned whole words inside the first kilobyte are mapped
  assign word_ok    = (hsize_in == 3'h2) && (haddr_in[1:0] == 2'h0) && (haddr_in[31:10] == 22'h000000);

  // Read data is formed from the address and handed out in the data phase
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (addr_phase && !hwrite_in && word_ok) begin
      if (acc_idx == `LSS_IDX_SENSE_STATUS) begin
        nxt_hrdata = {24'h000000, line_sense_status};
      end else if (acc_idx == `LSS_IDX_CONTROL) begin
        nxt_hrdata = {26'h0000000, ctl_ff};
      end else if (acc_idx == `LSS_IDX_IRQ_STATUS) begin
        nxt_hrdata = {28'h0000000, irq_status_ff};
      end else if (acc_idx == `LSS_IDX_IRQ_MASK) begin
        nxt_hrdata = {28'h0000000, irq_mask_ff};
      end else begin
        nxt_hrdata = 32'h00000000;
      end
    end
  end

  // Bus handshake registers; the slave never inserts wait states
  always @(posedge mclk_in) begin
    if (reset_in) begin
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_ff    <= 1'b0;
      wr_idx_ff     <= 8'h00;
    end else begin
      hrdata_out    <= nxt_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_ff    <= addr_phase & hwrite_in & word_ok;
      wr_idx_ff     <= acc_idx;
    end
  end

  // *********************************************************
  // AHB-Lite data phase writes
  // *********************************************************
  // Status register has no write path at all, and reading changes nothing
  always @* begin
    nxt_ctl        = ctl_ff;
    nxt_irq_mask   = irq_mask_ff;
    nxt_irq_status = irq_status_ff;
    if (wr_pend_ff) begin
      if (wr_idx_ff == `LSS_IDX_CONTROL) begin
        nxt_ctl = hwdata_in[`LSS_CTL_WIDTH-1:0];
      end else if (wr_idx_ff == `LSS_IDX_IRQ_MASK) begin
        nxt_irq_mask = hwdata_in[`LSS_IRQ_WIDTH-1:0];
      end else if (wr_idx_ff == `LSS_IDX_IRQ_STATUS) begin
        nxt_irq_status = irq_status_ff & ~hwdata_in[`LSS_IRQ_WIDTH-1:0];
      end
    end
    // A new event in the clearing cycle survives the clear
    nxt_irq_status = nxt_irq_status | event_rise;
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      ctl_ff        <= `LSS_CTL_RESET;
      irq_mask_ff   <= `LSS_IRQ_RESET;
      irq_status_ff <= `LSS_IRQ_RESET;
    end else begin
      ctl_ff        <= nxt_ctl;
      irq_mask_ff   <= nxt_irq_mask;
      irq_status_ff <= nxt_irq_status;
    end
  end

  // *********************************************************
  // Outputs
  // *********************************************************
  // Interrupt lags status by one cycle so that it comes from a flip-flop
  always @(posedge mclk_in) begin
    if (reset_in) begin
      irq_out                      <= 1'b0;
      off_hook_out                 <= 1'b0;
      rx_overload_latched_flag_out <= 1'b0;
    end else begin
      irq_out                      <= |(irq_status_ff & irq_mask_ff);
      off_hook_out                 <= hook_state_select;
      rx_overload_latched_flag_out <= rx_overload_latched_flag_ff;
    end
  end

endmodule // lss_top

/* File: test/lss_top_properties.sv */
// Checker for the line sense status block, watching the top-level ports only.
// Assumes one AHB-Lite master with hready tied to the slave's hreadyout.
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module lss_checker (
  input wire        mclk_in,            // Clock
  input wire        reset_in,           // Reset
  input wire        hsel_in,            // Select
  input wire [31:0] haddr_in,           // Address
  input wire [1:0]  htrans_in,          // Transfer type
  input wire        hwrite_in,          // Write
  input wire [2:0]  hsize_in,           // Size
  input wire        hready_in,          // Bus ready
  input wire [31:0] hrdata_out,         // Read data
  input wire        hreadyout_out,      // Slave ready
  input wire        hresp_out,          // Response
  input wire        off_hook_out,       // Hook state
  input wire        supply_ok_in,       // Supply good
  input wire        rx_excess_in,       // Receive excess
  input wire        protect_circuit_in  // Protection clamping
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // A taken transfer, and a taken read of the sense status word
  sequence s_take; hsel_in && htrans_in[1] && hready_in; endsequence
  sequence s_rd_st; s_take ##0 (!hwrite_in && haddr_in == 32'h0000_004C && hsize_in == 3'h2); endsequence
  property p_bus_ok; hreadyout_out && !hresp_out; endproperty
  property p_idle_zero; !(hsel_in && htrans_in[1] && hready_in) |=> hrdata_out == 32'h0; endproperty
  property p_unmapped; s_take ##0 (!hwrite_in && haddr_in[31:10] != 22'h0) |=> hrdata_out == 32'h0; endproperty
  property p_upper; s_rd_st |=> hrdata_out[31:8] == 24'h0; endproperty
  // Three quiet cycles give the status word time to follow the input
  property p_prot_low; (!protect_circuit_in)[*3] ##0 s_rd_st |=> !hrdata_out[0]; endproperty
  property p_do_onhook; (!off_hook_out)[*3] ##0 s_rd_st |=> !hrdata_out[1]; endproperty
  property p_do_set; (off_hook_out && !supply_ok_in)[*3] ##0 s_rd_st |=> hrdata_out[1]; endproperty
  property p_rx_clear; (!rx_excess_in)[*3] ##0 s_rd_st |=> !hrdata_out[2]; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("slave not ready or not okay");
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_upper: assert property (p_upper) else $error("status upper bits not zero");
  a_prot_low: assert property (p_prot_low) else $error("protect bit set while inactive");
  a_do_onhook: assert property (p_do_onhook) else $error("dropout set while on-hook");
  a_do_set: assert property (p_do_set) else $error("dropout not set on collapse");
  a_rx_clear: assert property (p_rx_clear) else $error("rx overload not self clearing");
endmodule // lss_checker

bind lss_top lss_checker chk_u (.mclk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
  .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .off_hook_out, .supply_ok_in, .rx_excess_in,
  .protect_circuit_in);

/* File: test/lss_line_model.sv */
// Model of the telephone line seen by the sensing front end.
// Assumes commands from the bench; loop current flows only while off-hook.
`timescale 1ns/1ns
// ****************************************
// Line model
// ****************************************
module lss_line_model (
  input  wire       mclk_in,      // Clock
  input  wire       off_hook_in,  // Hook state
  input  wire [4:0] volt_cmd_in,  // Line voltage code
  input  wire [4:0] mon_cmd_in,   // Monitor code
  input  wire [4:0] cur_cmd_in,   // Loop current code
  input  wire [4:0] flag_cmd_in,  // High, low, rx, supply, protect
  output reg  [4:0] volt_out,     // To voltage quantizer
  output reg  [4:0] mon_out,      // To monitor quantizer
  output reg  [4:0] cur_out,      // To current quantizer
  output reg  [4:0] flag_out      // To comparators
);
  initial begin
    {volt_out, mon_out, cur_out, flag_out} = 20'h00002;
  end
  // No loop current or current overload can exist while on-hook
  always @(posedge mclk_in) begin
    volt_out <= volt_cmd_in;
    mon_out  <= mon_cmd_in;
    cur_out  <= off_hook_in ? cur_cmd_in : 5'h00;
    flag_out <= {flag_cmd_in[4:3] & {2{off_hook_in}}, flag_cmd_in[2:0]};
  end
endmodule // lss_line_model

/* File: test/testbench.sv */
// Self-checking bench for the line sense status block.
// Assumes the design answers with zero wait states; waits are still bounded.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  localparam SF = 3;
  localparam DF = 4;
  logic        mclk_in = 0, reset_in = 1, hsel = 0, hwrite = 0, tick_r = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, seed = 32'h0001_4867;
  logic [1:0]  htrans = 0;
  logic [4:0]  volt_c = 0, mon_c = 0, cur_c = 0, flag_c = 5'h02;
  logic [5:0]  ctl = 0;
  logic        exp_rx = 0, exp_do = 0;
  wire  [31:0] hrdata;
  wire  [4:0]  volt_w, mon_w, cur_w, flag_w;
  wire         hready, hresp, irq, hook, rx_lat;
  int          fail_count = 0, tests_run = 0, cyc = 0, i;
  always #50 mclk_in = ~mclk_in;
  lss_top #(.SETTLE_FRAMES(SF), .DROPOUT_FRAMES(DF)) dut_u (.mclk_in(mclk_in), .reset_in(reset_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .irq_out(irq), .volt_code_in(volt_w), .monitor_code_in(mon_w), .current_code_in(cur_w),
    .over_high_in(flag_w[4]), .over_low_in(flag_w[3]), .rx_excess_in(flag_w[2]), .supply_ok_in(flag_w[1]),
    .protect_circuit_in(flag_w[0]), .frame_tick_in(tick_r), .off_hook_out(hook),
    .rx_overload_latched_flag_out(rx_lat));
  lss_line_model line_u (.mclk_in(mclk_in), .off_hook_in(hook), .volt_cmd_in(volt_c), .mon_cmd_in(mon_c),
    .cur_cmd_in(cur_c), .flag_cmd_in(flag_c), .volt_out(volt_w), .mon_out(mon_w), .cur_out(cur_w),
    .flag_out(flag_w));
  // ****************************************
  // Reference model and bus tasks
  // ****************************************
  function automatic [7:0] exp_st();
    logic [4:0] c;
    if (!ctl[0]) c = ctl[1] ? mon_c : volt_c;
    else if (ctl[2]) c = volt_c;
    else if (ctl[3] ? flag_c[3] : flag_c[4]) c = 5'h1F;
    else c = (cur_c > 5'h1E) ? 5'h1E : cur_c;
    return {c, exp_rx, exp_do, flag_c[0] & ctl[5]};
  endfunction
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Address phase held until ready, then data phase held until ready
  task ahb(input logic w, input [31:0] a, input [31:0] d);
    @(posedge mclk_in);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    do @(posedge mclk_in); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task setctl(input [5:0] v);
    ctl = v;
    ahb(1, 32'h80, {26'h0, v});
    repeat (4) @(posedge mclk_in);
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge mclk_in) tick_r <= 1;
      @(posedge mclk_in) tick_r <= 0;
      repeat (3) @(posedge mclk_in);
    end
  endtask
  task chk_st;
    repeat (3) @(posedge mclk_in);
    ahb(0, 32'h4C, 0);
    `CHK("status", exp_st(), rd)
  endtask
  task tally_and_finish;
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk_in);
    reset_in <= 0;
    chk_st();
    ahb(0, 32'h80, 0); `CHK("control", 32'h0, rd)
    ahb(0, 32'h400, 0); `CHK("unmapped", 32'h0, rd)
    // Random codes and modes; writes to the status word must be ignored
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      @(posedge mclk_in);
      {volt_c, mon_c, cur_c} <= seed[14:0];
      flag_c <= {seed[16:15], 2'b01, seed[17]};
      setctl({seed[21:20], seed[19], seed[18] & seed[22], seed[23], seed[24]});
      ahb(1, 32'h4C, seed);
      chk_st();
    end
    // Dropout set, counted release, and its interrupt
    @(posedge mclk_in) flag_c <= 5'h02;
    setctl(6'h01);
    ahb(1, 32'h84, 32'hF);
    ahb(1, 32'h88, 32'h2);
    @(posedge mclk_in) flag_c <= 5'h00;
    exp_do = 1;
    chk_st();
    `CHK("irq", 1'b1, irq)
    @(posedge mclk_in) flag_c <= 5'h02;
    tick(DF - 1);
    chk_st();
    tick(1);
    exp_do = 0;
    chk_st();
    ahb(0, 32'h84, 0); `CHK("irq status", 32'h2, rd)
    ahb(1, 32'h84, 32'h2);
    repeat (2) @(posedge mclk_in);
    `CHK("irq", 1'b0, irq)
    @(posedge mclk_in) flag_c <= 5'h00;
    setctl(6'h00);
    chk_st();
    @(posedge mclk_in) flag_c <= 5'h02;
    // Receive overload hidden while settling, billing enable has no say
    setctl(6'h11);
    ahb(1, 32'h88, 32'h1);
    @(posedge mclk_in) flag_c <= 5'h06;
    chk_st();
    tick(SF);
    exp_rx = 1;
    chk_st();
    `CHK("latched", 1'b1, rx_lat)
    `CHK("irq", 1'b1, irq)
    @(posedge mclk_in) flag_c <= 5'h02;
    exp_rx = 0;
    chk_st();
    ahb(1, 32'h84, 32'h1);
    repeat (3) @(posedge mclk_in);
    `CHK("latched", 1'b0, rx_lat)
    `CHK("irq", 1'b0, irq)
    tally_and_finish();
  end
endmodule // testbench
